// ### verilog/ppf_params.svh
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH

// register byte offsets
`define PPF_REG_CTRL 8'h00
`define PPF_REG_WIN_Y 8'h04
`define PPF_REG_XKERN 8'h08
`define PPF_REG_TIMING 8'h0C
`define PPF_REG_EXPO 8'h10
`define PPF_REG_STATUS 8'h14

// control register fields
`define PPF_CTRL_START 0
`define PPF_CTRL_BL_FRAME 1
`define PPF_CTRL_BL_LINE 2
`define PPF_CTRL_MODE_LO 4
`define PPF_CTRL_MODE_HI 6
`define PPF_CTRL_WORD8 8

// window and timing fields
`define PPF_WIN_YSTART_LO 0
`define PPF_WIN_YSTART_HI 11
`define PPF_WIN_YEND_LO 16
`define PPF_WIN_YEND_HI 27
`define PPF_XK_HI 8
`define PPF_TIM_ROT_LO 0
`define PPF_TIM_ROT_HI 7
`define PPF_TIM_BLK_LO 8
`define PPF_TIM_BLK_HI 15
`define PPF_EXPO_HI 15

// status fields
`define PPF_STAT_BUSY 0
`define PPF_STAT_STATE_LO 1
`define PPF_STAT_STATE_HI 3
`define PPF_STAT_WORD10 4
`define PPF_STAT_ROW_LO 16
`define PPF_STAT_ROW_HI 27

// reset values
`define PPF_RST_YSTART 12'h000
`define PPF_RST_YEND 12'h9C3
`define PPF_RST_XKERN 9'h1E0
`define PPF_RST_ROT 8'h10
`define PPF_RST_BLK 8'h08
`define PPF_RST_EXPO 16'h0100

// data path constants
`define PPF_TRAIN_WORD 10'h3A5
`define PPF_CRC_POLY 10'h24F
`define PPF_CRC_SEED 10'h3FF

`endif

// ### verilog/ppf_pkg.sv
package ppf_pkg;

    typedef enum logic [2:0] {
        PPF_IDLE = 3'h0,
        PPF_RST = 3'h1,
        PPF_EXPO = 3'h3,
        PPF_ROT = 3'h2,
        PPF_LINE = 3'h6,
        PPF_CRC = 3'h7
    } ppf_state_e;

    typedef enum logic [2:0] {
        PPF_M_NONE = 3'h0,
        PPF_M_SKIP = 3'h1,
        PPF_M_CHECKER = 3'h2,
        PPF_M_BIN12 = 3'h3,
        PPF_M_BIN22 = 3'h4
    } ppf_mode_e;

    // four neighbours from the pixel array: (r,c) (r,c+1) (r+1,c) (r+1,c+1)
    typedef struct packed {
        logic [9:0] p00;
        logic [9:0] p01;
        logic [9:0] p10;
        logic [9:0] p11;
    } ppf_quad_s;

    typedef struct packed {
        logic bl_frame_en;
        logic bl_line_en;
        ppf_mode_e mode;
        logic [11:0] y_start;
        logic [11:0] y_end;
        logic [8:0] x_kernels;
        logic [7:0] row_overhead_idle;
        logic [7:0] black_rows;
        logic [15:0] expo;
    } ppf_cfg_s;

    // parallel output pins
    typedef struct packed {
        logic out_clk;
        logic frame_strobe;
        logic row_strobe;
        logic [9:0] data;
    } ppf_pins_s;

endpackage : ppf_pkg

// ### verilog/ppf_framer.sv
`include "ppf_params.svh"

// What this block does
// - only 10-bit words; an 8-bit request is ignored.
// - frame strobe rises at frame start, falls after last line fully sent.
// - data is a valid pixel whenever the row strobe is high.
// - row strobe high per line, low during row overhead idle.
// - a CRC word follows each line right after the row strobe falls.
// - lines read one by one, left to right, bottom row upward.
// - rows reset y start to y end, one line time apart.
// - after exposure, each row read after one row overhead interval.
// - both black enables set: black rows handled as image rows.
// - frame enable only: frame strobe covers black rows, row strobe does not.
// - line enable only: row strobe marks black pixels, frame strobe skips them.
// - both cleared: strobes low in black rows, data and CRC still sent.
// - readout in kernels of eight pixels by one row.
// - no subsampling: kernel pairs, even pairs ascending, odd pairs descending.
// - read-1-skip-1: even pixels of 8-pixel kernels, same order always.
// - checkerboard: even pixels of one row, odd pixels of next.
// - 1x2 binning: no-subsampling order, pixel joined with next row.
// - 2x2 binning: skip order, joined with odd neighbour and next row.
// - single 10-bit output with forwarded clock and both strobes.
// - no window information is sent on the output.
module ppf_framer import ppf_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pix_clk,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ppf_quad_s arr_data,
    output logic [11:0] arr_row,
    output logic [11:0] arr_col,
    output logic arr_black,
    output logic row_reset,
    output logic [11:0] row_reset_addr,
    output ppf_pins_s pins
);

    ////////////////////////////////////////////////////////////////////////////
    // pixel clock sampling

    logic pclk_s1_q, pclk_s2_q, pclk_s3_q;
    logic tick;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
        end else begin
            pclk_s1_q <= pix_clk;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
        end
    end

    assign tick = pclk_s2_q & ~pclk_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // register slave

    ppf_cfg_s cfg_q, cfg_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic start_q, start_d;
    logic take;
    ppf_state_e st_q, st_d;
    logic [11:0] row_q, row_d;

    assign take = (avs_read | avs_write) & ~wait_q;

    always_comb begin
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        start_d = 1'b0;
        wait_d = 1'b1;
        if ((avs_read | avs_write) && wait_q) begin
            wait_d = 1'b0;
        end
        if (take && avs_write) begin
            case (avs_address)
                `PPF_REG_CTRL: begin
                    start_d = avs_writedata[`PPF_CTRL_START] & (st_q == PPF_IDLE);
                    cfg_d.bl_frame_en = avs_writedata[`PPF_CTRL_BL_FRAME];
                    cfg_d.bl_line_en = avs_writedata[`PPF_CTRL_BL_LINE];
                    cfg_d.mode = ppf_mode_e'(avs_writedata[`PPF_CTRL_MODE_HI:`PPF_CTRL_MODE_LO]);
                    // the word-width bit is dropped: this output is 10-bit only
                end
                `PPF_REG_WIN_Y: begin
                    cfg_d.y_start = avs_writedata[`PPF_WIN_YSTART_HI:`PPF_WIN_YSTART_LO];
                    cfg_d.y_end = avs_writedata[`PPF_WIN_YEND_HI:`PPF_WIN_YEND_LO];
                end
                `PPF_REG_XKERN: cfg_d.x_kernels = avs_writedata[`PPF_XK_HI:0];
                `PPF_REG_TIMING: begin
                    cfg_d.row_overhead_idle = avs_writedata[`PPF_TIM_ROT_HI:`PPF_TIM_ROT_LO];
                    cfg_d.black_rows = avs_writedata[`PPF_TIM_BLK_HI:`PPF_TIM_BLK_LO];
                end
                `PPF_REG_EXPO: cfg_d.expo = avs_writedata[`PPF_EXPO_HI:0];
                default: begin
                end
            endcase
        end
        if ((avs_read | avs_write) && wait_q) begin
            rdata_d = 32'h0000_0000;
            if (avs_read) begin
                case (avs_address)
                    `PPF_REG_CTRL: begin
                        rdata_d[`PPF_CTRL_BL_FRAME] = cfg_q.bl_frame_en;
                        rdata_d[`PPF_CTRL_BL_LINE] = cfg_q.bl_line_en;
                        rdata_d[`PPF_CTRL_MODE_HI:`PPF_CTRL_MODE_LO] = cfg_q.mode;
                    end
                    `PPF_REG_WIN_Y: begin
                        rdata_d[`PPF_WIN_YSTART_HI:`PPF_WIN_YSTART_LO] = cfg_q.y_start;
                        rdata_d[`PPF_WIN_YEND_HI:`PPF_WIN_YEND_LO] = cfg_q.y_end;
                    end
                    `PPF_REG_XKERN: rdata_d[`PPF_XK_HI:0] = cfg_q.x_kernels;
                    `PPF_REG_TIMING: begin
                        rdata_d[`PPF_TIM_ROT_HI:`PPF_TIM_ROT_LO] = cfg_q.row_overhead_idle;
                        rdata_d[`PPF_TIM_BLK_HI:`PPF_TIM_BLK_LO] = cfg_q.black_rows;
                    end
                    `PPF_REG_EXPO: rdata_d[`PPF_EXPO_HI:0] = cfg_q.expo;
                    `PPF_REG_STATUS: begin
                        rdata_d[`PPF_STAT_BUSY] = (st_q != PPF_IDLE);
                        rdata_d[`PPF_STAT_STATE_HI:`PPF_STAT_STATE_LO] = st_q;
                        rdata_d[`PPF_STAT_WORD10] = 1'b1;
                        rdata_d[`PPF_STAT_ROW_HI:`PPF_STAT_ROW_LO] = row_q;
                    end
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_q <= '{bl_frame_en: 1'b1, bl_line_en: 1'b1, mode: PPF_M_NONE,
                       y_start: `PPF_RST_YSTART, y_end: `PPF_RST_YEND,
                       x_kernels: `PPF_RST_XKERN, row_overhead_idle: `PPF_RST_ROT,
                       black_rows: `PPF_RST_BLK, expo: `PPF_RST_EXPO};
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            start_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            start_q <= start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pixel ordering and binning

    // column of output word n inside a line
    function automatic logic [11:0] col_of(input logic [11:0] n, input ppf_mode_e m,
                                           input logic odd_row);
        logic [11:0] c;
        c = n;
        case (m)
            PPF_M_SKIP, PPF_M_BIN22: c = {n[10:0], 1'b0};
            PPF_M_CHECKER: c = {n[10:0], odd_row};
            default: c = n[4] ? {n[11:4], ~n[3:0]} : n;
        endcase
        return c;
    endfunction : col_of

    function automatic logic [9:0] crc_step(input logic [9:0] crc, input logic [9:0] w);
        logic [9:0] c;
        c = crc;
        for (int i = 9; i >= 0; i--) begin
            c = (c[9] ^ w[i]) ? ({c[8:0], 1'b0} ^ `PPF_CRC_POLY) : {c[8:0], 1'b0};
        end
        return c;
    endfunction : crc_step

    logic half_len, two_rows, odd_row;
    logic [11:0] line_len;
    logic [12:0] line_time;
    logic [11:0] sum2, sum4;
    logic [9:0] pix_word;

    assign half_len = (cfg_q.mode == PPF_M_SKIP) || (cfg_q.mode == PPF_M_CHECKER)
                      || (cfg_q.mode == PPF_M_BIN22);
    assign two_rows = (cfg_q.mode == PPF_M_BIN12) || (cfg_q.mode == PPF_M_BIN22);
    assign line_len = half_len ? {1'b0, cfg_q.x_kernels, 2'b00} : {cfg_q.x_kernels, 3'b000};
    assign line_time = {1'b0, line_len} + {5'h00, cfg_q.row_overhead_idle};
    assign odd_row = row_q[0] ^ cfg_q.y_start[0];
    assign sum2 = {2'b00, arr_data.p00} + {2'b00, arr_data.p10};
    assign sum4 = sum2 + {2'b00, arr_data.p01} + {2'b00, arr_data.p11};

    always_comb begin
        case (cfg_q.mode)
            PPF_M_BIN12: pix_word = sum2[10:1];
            PPF_M_BIN22: pix_word = sum4[11:2];
            default: pix_word = arr_data.p00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer

    logic [15:0] tcnt_q, tcnt_d;
    logic [11:0] n_q, n_d;
    logic [7:0] blk_q, blk_d;
    logic black_q, black_d;
    logic frame_q, frame_d;
    logic rstrb_q, rstrb_d;
    logic [9:0] dout_q, dout_d;
    logic [9:0] crc_q, crc_d;
    logic rrst_q, rrst_d;
    logic [11:0] rrst_row_q, rrst_row_d;
    logic [11:0] arow_q, arow_d;
    logic [11:0] acol_q, acol_d;
    logic ablk_q, ablk_d;
    logic oclk_q;
    logic [12:0] next_row;
    logic last_row;

    assign next_row = {1'b0, row_q} + (two_rows ? 13'h0002 : 13'h0001);
    assign last_row = ~black_q && (next_row > {1'b0, cfg_q.y_end});

    always_comb begin
        st_d = st_q;
        tcnt_d = tcnt_q;
        n_d = n_q;
        row_d = row_q;
        blk_d = blk_q;
        black_d = black_q;
        frame_d = frame_q;
        rstrb_d = rstrb_q;
        dout_d = dout_q;
        crc_d = crc_q;
        rrst_d = 1'b0;
        rrst_row_d = rrst_row_q;
        // array address follows the word counter; data is ready by the next tick
        arow_d = black_q ? {4'h0, blk_q} : row_q;
        acol_d = col_of(n_q, cfg_q.mode, odd_row);
        ablk_d = black_q;
        case (st_q)
            PPF_IDLE: begin
                dout_d = `PPF_TRAIN_WORD;
                if (start_q) begin
                    row_d = cfg_q.y_start;
                    rrst_d = 1'b1;
                    rrst_row_d = cfg_q.y_start;
                    tcnt_d = 16'h0000;
                    st_d = PPF_RST;
                end
            end
            PPF_RST: if (tick) begin
                tcnt_d = tcnt_q + 16'h0001;
                if (tcnt_d[12:0] >= line_time) begin
                    tcnt_d = 16'h0000;
                    if (row_q >= cfg_q.y_end) begin
                        st_d = PPF_EXPO;
                    end else begin
                        row_d = row_q + 12'h001;
                        rrst_d = 1'b1;
                        rrst_row_d = row_d;
                    end
                end
            end
            PPF_EXPO: if (tick) begin
                tcnt_d = tcnt_q + 16'h0001;
                if (tcnt_d >= cfg_q.expo) begin
                    tcnt_d = 16'h0000;
                    row_d = cfg_q.y_start;
                    blk_d = 8'h00;
                    black_d = (cfg_q.black_rows != 8'h00);
                    // frame strobe before the first black row only when enabled
                    frame_d = (cfg_q.black_rows == 8'h00) | cfg_q.bl_frame_en;
                    st_d = PPF_ROT;
                end
            end
            PPF_ROT: begin
                if (!black_q) begin
                    frame_d = 1'b1;
                end
                if (tick) begin
                    dout_d = `PPF_TRAIN_WORD;
                    tcnt_d = tcnt_q + 16'h0001;
                    if (tcnt_d >= {8'h00, cfg_q.row_overhead_idle}) begin
                        tcnt_d = 16'h0000;
                        n_d = 12'h000;
                        crc_d = `PPF_CRC_SEED;
                        st_d = PPF_LINE;
                    end
                end
            end
            PPF_LINE: if (tick) begin
                dout_d = pix_word;
                // black rows are strobed only when the line enable is set
                rstrb_d = ~black_q | cfg_q.bl_line_en;
                crc_d = crc_step(crc_q, pix_word);
                n_d = n_q + 12'h001;
                if (n_d >= line_len) begin
                    tcnt_d = 16'h0000;
                    st_d = PPF_CRC;
                end
            end
            PPF_CRC: if (tick) begin
                rstrb_d = 1'b0;
                if (tcnt_q == 16'h0000) begin
                    dout_d = crc_q;
                    tcnt_d = 16'h0001;
                end else begin
                    dout_d = `PPF_TRAIN_WORD;
                    n_d = 12'h000;
                    if (last_row) begin
                        frame_d = 1'b0;
                        st_d = PPF_IDLE;
                    end else begin
                        if (black_q) begin
                            blk_d = blk_q + 8'h01;
                            black_d = (blk_d != cfg_q.black_rows);
                        end else begin
                            row_d = next_row[11:0];
                        end
                        st_d = PPF_ROT;
                    end
                end
            end
            default: st_d = PPF_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= PPF_IDLE;
            tcnt_q <= 16'h0000;
            n_q <= 12'h000;
            row_q <= 12'h000;
            blk_q <= 8'h00;
            black_q <= 1'b0;
            frame_q <= 1'b0;
            rstrb_q <= 1'b0;
            dout_q <= `PPF_TRAIN_WORD;
            crc_q <= `PPF_CRC_SEED;
            rrst_q <= 1'b0;
            rrst_row_q <= 12'h000;
            arow_q <= 12'h000;
            acol_q <= 12'h000;
            ablk_q <= 1'b0;
            oclk_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tcnt_q <= tcnt_d;
            n_q <= n_d;
            row_q <= row_d;
            blk_q <= blk_d;
            black_q <= black_d;
            frame_q <= frame_d;
            rstrb_q <= rstrb_d;
            dout_q <= dout_d;
            crc_q <= crc_d;
            rrst_q <= rrst_d;
            rrst_row_q <= rrst_row_d;
            arow_q <= arow_d;
            acol_q <= acol_d;
            ablk_q <= ablk_d;
            // forwarded clock is inverted so data moves on its falling edge
            oclk_q <= ~pclk_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign arr_row = arow_q;
    assign arr_col = acol_q;
    assign arr_black = ablk_q;
    assign row_reset = rrst_q;
    assign row_reset_addr = rrst_row_q;
    // only clock, strobes and data leave: no window information
    assign pins = '{out_clk: oclk_q, frame_strobe: frame_q, row_strobe: rstrb_q, data: dout_q};

endmodule : ppf_framer

// ### sim/ppf_rx_model.sv
module ppf_rx_model import ppf_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire ppf_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q = 1'b1;
    logic rs_q = 1'b0;
    logic fs_q = 1'b0;
    logic [9:0] words[$];
    logic [9:0] crcs[$];
    int lines = 0;
    int loose = 0;
    int frames = 0;
    // capture logic: samples only at rising edges of the forwarded clock
    always @(posedge core_clk) begin
        clk_q <= pins.out_clk;
        if (!rst && !clk_q && pins.out_clk) begin
            rs_q <= pins.row_strobe;
            fs_q <= pins.frame_strobe;
            if (pins.row_strobe) begin
                words.push_back(pins.data);
                if (!pins.frame_strobe) loose++;
            end
            if (rs_q && !pins.row_strobe) crcs.push_back(pins.data);
            if (!rs_q && pins.row_strobe) lines++;
            if (!fs_q && pins.frame_strobe) frames++;
        end
    end
endmodule : ppf_rx_model

// ### sim/ppf_framer_assertions.sv
`include "ppf_params.svh"

module ppf_framer_checker import ppf_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic row_reset,
    input wire ppf_pins_s pins
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");

    property p_req_answer;
        $rose(avs_read || avs_write) |=> !avs_waitrequest;
    endproperty
    a_req_answer: assert property (p_req_answer) else $error("request not answered");

    property p_word10;
        avs_read && !avs_waitrequest && avs_address == `PPF_REG_STATUS |-> avs_readdata[4];
    endproperty
    a_word10: assert property (p_word10) else $error("word size not 10");

    property p_no_word8;
        avs_read && !avs_waitrequest && avs_address == `PPF_REG_CTRL |-> !avs_readdata[8];
    endproperty
    a_no_word8: assert property (p_no_word8) else $error("8-bit mode taken");

    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > `PPF_REG_STATUS |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_crc_hold;
        $fell(pins.row_strobe) |-> ##1 $stable(pins.data) [*6];
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("check word not held");

    property p_frame_end;
        $fell(pins.frame_strobe) |-> !pins.row_strobe && !$past(pins.row_strobe, 4);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame ended in line");

    property p_row_min;
        $rose(pins.row_strobe) |-> pins.row_strobe [*8];
    endproperty
    a_row_min: assert property (p_row_min) else $error("row strobe too short");

    property p_clk_low;
        $fell(pins.out_clk) && !$past(rst, 4) |-> !pins.out_clk [*4];
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("out clock low too short");

    property p_data_on_fall;
        ($changed(pins.data) || $changed(pins.row_strobe)) && !$past(rst, 2)
            |-> $fell(pins.out_clk);
    endproperty
    a_data_on_fall: assert property (p_data_on_fall) else $error("data off clock");

    property p_reset_gap;
        row_reset |=> !row_reset [*8];
    endproperty
    a_reset_gap: assert property (p_reset_gap) else $error("row resets too close");
endmodule : ppf_framer_checker

bind ppf_framer ppf_framer_checker i_chk (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .row_reset(row_reset), .pins(pins));

// ### sim/tb_top.sv
`include "ppf_params.svh"

module tb_top import ppf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        int mode;
        logic fen;
        logic len;
        int nblk;
        int lines;
        int loose;
    } ppf_case_s;
    ppf_case_s cases[8] = '{'{0, 1, 1, 1, 3, 0}, '{0, 1, 0, 1, 2, 0}, '{0, 0, 1, 1, 3, 32},
        '{0, 0, 0, 1, 2, 0}, '{1, 1, 1, 0, 2, 0}, '{2, 1, 1, 0, 2, 0}, '{3, 1, 1, 0, 1, 0},
        '{4, 1, 1, 0, 1, 0}};
    logic [7:0] rv_a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] rv_e[5] = '{32'h6, 32'h09C30000, 32'h1E0, 32'h0810, 32'h100};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic pix_clk = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    ppf_quad_s arr_data;
    logic [11:0] arr_row;
    logic [11:0] arr_col;
    logic arr_black;
    logic row_reset;
    logic [11:0] row_reset_addr;
    ppf_pins_s pins;
    logic [31:0] rd;
    int miscompares = 0;
    int num_checks = 0;
    int rr_n = 0;

    always #5 core_clk = ~core_clk;
    initial begin
        #13;
        forever #40 pix_clk = ~pix_clk;
    end

    function automatic logic [9:0] pix(input logic b, input logic [11:0] r, input logic [11:0] c);
        return {b, r[3:0], c[4:0]};
    endfunction : pix

    assign arr_data = {pix(arr_black, arr_row, arr_col), pix(arr_black, arr_row, arr_col + 12'h1),
        pix(arr_black, arr_row + 12'h1, arr_col), pix(arr_black, arr_row + 12'h1, arr_col + 12'h1)};

    ppf_framer i_dut (.core_clk(core_clk), .rst(rst), .pix_clk(pix_clk),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .arr_data(arr_data), .arr_row(arr_row),
        .arr_col(arr_col), .arr_black(arr_black), .row_reset(row_reset),
        .row_reset_addr(row_reset_addr), .pins(pins));
    ppf_rx_model i_rx (.core_clk(core_clk), .rst(rst), .pins(pins));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        @(posedge core_clk);
    endtask : bus

    function automatic logic [9:0] exp_word(input int m, input logic b, input logic [11:0] r,
                                            input logic [11:0] n);
        logic [11:0] c;
        logic [11:0] s;
        c = n[4] ? {n[11:4], ~n[3:0]} : n;
        if (m == 1 || m == 4) c = n << 1;
        if (m == 2) c = (n << 1) + r[0];
        s = pix(b, r, c);
        if (m == 3) s = (s + pix(b, r + 12'h1, c)) >> 1;
        if (m == 4) s = (s + pix(b, r, c + 12'h1) + pix(b, r + 12'h1, c)
            + pix(b, r + 12'h1, c + 12'h1)) >> 2;
        return s[9:0];
    endfunction : exp_word

    function automatic logic [9:0] crc_step(input logic [9:0] crc, input logic [9:0] w);
        for (int i = 9; i >= 0; i--) crc = {crc[8:0], 1'b0} ^ ((crc[9] ^ w[i]) ? `PPF_CRC_POLY : 10'h000);
        return crc;
    endfunction : crc_step

    // row reset pointer walks the window rows in order
    always @(posedge core_clk) begin
        if (!rst && row_reset === 1'b1) begin
            chk({20'h0, row_reset_addr}, 32'h4 + rr_n);
            rr_n++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_case(input ppf_case_s c);
        int w;
        int l;
        int len;
        logic blk;
        logic [11:0] row;
        logic [9:0] e;
        logic [9:0] crc;
        w = 0;
        l = 0;
        len = (c.mode == 0 || c.mode == 3) ? 32 : 16;
        i_rx.words.delete();
        i_rx.crcs.delete();
        i_rx.lines = 0;
        i_rx.loose = 0;
        i_rx.frames = 0;
        rr_n = 0;
        bus(1'b1, `PPF_REG_TIMING, {16'h0, c.nblk[7:0], 8'h02}, rd);
        bus(1'b1, `PPF_REG_CTRL, {25'h0, c.mode[2:0], 1'b0, c.len, c.fen, 1'b1}, rd);
        bus(1'b1, `PPF_REG_CTRL, {25'h0, c.mode[2:0], 1'b0, c.len, c.fen, 1'b1}, rd);
        rd = 32'h1;
        for (int k = 0; k < 3000 && rd[0] !== 1'b0; k++) bus(1'b0, `PPF_REG_STATUS, 32'h0, rd);
        chk(rd[0], 32'h0);
        repeat (100) @(posedge core_clk);
        for (int r = 0; r < c.nblk + 2; r++) begin
            blk = (r < c.nblk);
            row = blk ? r[11:0] : 12'(4 + r - c.nblk);
            if (blk ? c.len : !(c.mode >= 3 && row[0])) begin
                crc = `PPF_CRC_SEED;
                for (int n = 0; n < len; n++) begin
                    e = exp_word(c.mode, blk, row, n[11:0]);
                    crc = crc_step(crc, e);
                    chk(i_rx.words[w], e);
                    w++;
                end
                chk(i_rx.crcs[l], crc);
                l++;
            end
        end
        chk(i_rx.words.size(), w);
        chk(i_rx.lines, c.lines);
        chk(i_rx.loose, c.loose);
        chk(i_rx.frames, 1);
        chk(rr_n, 2);
    endtask : run_case

    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rv_a[i]) begin
            bus(1'b0, rv_a[i], 32'h0, rd);
            chk(rd, rv_e[i]);
        end
        bus(1'b0, `PPF_REG_STATUS, 32'h0, rd);
        chk(rd & 32'h1F, 32'h10);
        bus(1'b1, 8'h40, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, `PPF_REG_CTRL, 32'h106, rd);
        bus(1'b0, `PPF_REG_CTRL, 32'h0, rd);
        chk(rd, 32'h6);
        $display("register test done");
        bus(1'b1, `PPF_REG_WIN_Y, 32'h00050004, rd);
        bus(1'b1, `PPF_REG_XKERN, 32'h4, rd);
        bus(1'b1, `PPF_REG_EXPO, 32'h2, rd);
        foreach (cases[i]) begin
            run_case(cases[i]);
            $display("frame case %0d done", i);
        end
        rr_n = 0;
        bus(1'b1, `PPF_REG_CTRL, 32'h7, rd);
        repeat (700) @(posedge core_clk);
        chk(rr_n, 2);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk({pins.frame_strobe, pins.row_strobe, pins.data}, {2'b00, `PPF_TRAIN_WORD});
        bus(1'b0, `PPF_REG_STATUS, 32'h0, rd);
        chk(rd & 32'h1F, 32'h10);
        $display("mid-frame reset test done");
        complete_run();
    end
endmodule : tb_top
